// ===== design/rvc_cmd.sv
// regulator on/off, margin, store/restore and output set-point command decoder
// Notes on behaviour
// R1 - on/off field 00 immediate off, 01 soft off, 10 on
// R2 - on/off field counts only when bus enable mode is selected
// R3 - margin field 00 nominal, 01 margin low target, 10 margin high target
// R4 - fault field while margined: 01 ignore faults, 10 act on faults
// R5 - power-up bit set keeps output off until pin or bus turns it on
// R6 - bus enable bit 0 ignores on/off field, 1 needs an on command
// R7 - pin mode bit 0 ignores pin, 1 enables only while pin asserted
// R8 - pin polarity bit 0 low enables, 1 high enables
// R9 - pin turn-off action bit 0 soft off, 1 immediate off
// R10 - code 03 clears every fault status bit
// R11 - code 11 saves configuration to default store, locked unless unlocked
// R12 - code 12 reloads whole configuration from default store
// R13 - code 15 saves settings changed since last restore to user store
// R14 - host waits 20 ms after user store or restore before next command; the host model waits 200 cycles instead
// R15 - host extends user store by restore, writes, then store
// R16 - user restore runs at power-up, overriding default store values
// R17 - user restore sets security level to level one
// R18 - format byte bits 4:0 hold five-bit signed exponent
// R19 - format byte bits 7:5 give representation, 000 linear
// R20 - code 21 holds unsigned nominal set-point word
// R21 - code 22 holds signed trim offset limited to 150 mV either way
// R22 - code 23 holds signed calibration offset, limited like trim
// R23 - margin high and low targets live at codes 25 and 26
`include "rvc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module rvc_cmd
  import rvc_pkg::*;
(
  input  wire logic      sys_clk,       // 100 MHz clock
  input  wire logic      rst,           // async reset, active high
  input  wire logic      cmd_valid,     // command present
  output logic           cmd_ready,     // command can be taken
  input  wire rvc_kind_t cmd_kind,      // send byte, write or read
  input  wire logic [7:0]  cmd_code,    // command code
  input  wire logic [15:0] cmd_wdata,   // write data, bytes in low bits
  output logic           rsp_valid,     // one-cycle answer pulse
  output logic           rsp_err,       // command refused
  output rvc_word_t      rsp_rdata,     // read data
  input  wire logic      ctrl_pin,      // remote control pin level
  input  wire logic      dflt_unlock,   // lifts default store protection
  output logic           out_enable,    // output enabled
  output logic           out_fast_off,  // off is immediate, not ramped
  output logic [1:0]     out_margin,    // selected target
  output rvc_word_t      out_target,    // selected target voltage word
  output rvc_word_t      out_trim,      // trim offset word
  output rvc_word_t      out_cal,       // calibration offset word
  output logic           out_fault_ignore, // ignore ov/uv while margined
  output logic           fault_clear,   // one-cycle fault clear pulse
  output logic [1:0]     security_level // current security level
);

  localparam logic signed [15:0] TRIM_LIM =
    16'((`RVC_TRIM_LIMIT_MV * `RVC_VOLT_SCALE) / `RVC_MV_PER_V);
  localparam rvc_word_t RST_VAL [RVC_NREG] = '{`RVC_RST_ONOFF_CTRL, `RVC_RST_SRC_CFG,
    `RVC_RST_NOMINAL, `RVC_RST_TRIM, `RVC_RST_CAL, `RVC_RST_MARGIN_HI, `RVC_RST_MARGIN_LO};
  localparam logic [7:0] VFMT = {`RVC_FMT_LINEAR, `RVC_FMT_EXP};

  rvc_state_t           state;
  rvc_word_t            cfg_q  [RVC_NREG];
  rvc_word_t            dflt_q [RVC_NREG];
  rvc_word_t            user_q [RVC_NREG];
  logic [RVC_NREG-1:0]  user_valid;
  logic [RVC_NREG-1:0]  changed;
  rvc_idx_t             idx;
  logic                 hit;
  logic                 take;
  logic                 is_send;
  logic                 send_ok;
  logic                 ok;
  logic                 do_wr;
  logic                 do_rst_user;
  logic                 do_rst_dflt;
  logic                 do_st_user;
  logic                 do_st_dflt;
  logic [7:0]           op;
  logic [7:0]           cfg;
  logic                 pin_ok;
  logic                 bus_ok;
  logic                 next_enable;
  logic                 next_fast_off;
  logic [1:0]           next_margin;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // clamp signed offsets, keep byte registers to eight bits
  function automatic rvc_word_t fit(input rvc_idx_t i, input rvc_word_t w);
    logic signed [15:0] s;
    s = signed'(w);
    fit = w;
    if (i == RVC_I_OP || i == RVC_I_CFG) begin
      fit = {8'h00, w[7:0]};
    end else if (i == RVC_I_TRIM || i == RVC_I_CAL) begin
      if (s > TRIM_LIM) begin
        fit = TRIM_LIM;                                  // [R21] [R22]
      end else if (s < -TRIM_LIM) begin
        fit = -TRIM_LIM;                                 // [R21] [R22]
      end
    end
  endfunction

  // map a code to a stored register
  always_comb begin
    hit = 1'b1;
    idx = RVC_I_OP;
    unique case (cmd_code)
      `RVC_CODE_ONOFF_CTRL: idx = RVC_I_OP;
      `RVC_CODE_SRC_CFG:    idx = RVC_I_CFG;
      `RVC_CODE_NOMINAL:    idx = RVC_I_NOM;             // [R20]
      `RVC_CODE_TRIM:       idx = RVC_I_TRIM;            // [R21]
      `RVC_CODE_CAL:        idx = RVC_I_CAL;             // [R22]
      `RVC_CODE_MARGIN_HI:  idx = RVC_I_MHI;             // [R23]
      `RVC_CODE_MARGIN_LO:  idx = RVC_I_MLO;             // [R23]
      default:              hit = 1'b0;
    endcase
  end

  // send-byte legality; default store refuses while locked
  always_comb begin
    send_ok = 1'b1;
    unique case (cmd_code)
      `RVC_CODE_CLEAR_FAULTS,
      `RVC_CODE_RESTORE_DFLT,
      `RVC_CODE_STORE_USER,
      `RVC_CODE_RESTORE_USER: send_ok = 1'b1;
      `RVC_CODE_STORE_DFLT:   send_ok = dflt_unlock;     // [R11]
      default:                send_ok = 1'b0;
    endcase
  end

  assign cmd_ready   = (state == RVC_READY);
  assign take        = cmd_valid & cmd_ready;
  assign is_send     = take & (cmd_kind == RVC_SEND);
  assign ok          = (cmd_kind == RVC_SEND && send_ok) ||
                       (cmd_kind == RVC_WRITE && hit) ||
                       (cmd_kind == RVC_READ && (hit || cmd_code == `RVC_CODE_VFMT));
  assign do_wr       = take & (cmd_kind == RVC_WRITE) & hit;
  assign do_rst_user = (state == RVC_BOOT) |
                       (is_send & (cmd_code == `RVC_CODE_RESTORE_USER)); // [R16]
  assign do_rst_dflt = is_send & (cmd_code == `RVC_CODE_RESTORE_DFLT);
  assign do_st_user  = is_send & (cmd_code == `RVC_CODE_STORE_USER);
  assign do_st_dflt  = is_send & (cmd_code == `RVC_CODE_STORE_DFLT) & dflt_unlock;

  ////////////////////////////////////////////////////////////////////////////
  // boot sequence: one cycle of user restore after reset

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= RVC_BOOT;
    end else begin
      state <= RVC_READY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live configuration and the two stores

  // reset loads factory values; the boot cycle then applies the user store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < RVC_NREG; i++) begin
        cfg_q[i]  <= RST_VAL[i];
        dflt_q[i] <= RST_VAL[i];
        user_q[i] <= 16'h0000;
      end
      user_valid <= '0;
      changed    <= '0;
    end else if (do_rst_user) begin
      for (int i = 0; i < RVC_NREG; i++) begin
        if (user_valid[i]) begin
          cfg_q[i] <= user_q[i];                         // [R16]
        end
      end
      changed <= '0;
    end else if (do_rst_dflt) begin
      for (int i = 0; i < RVC_NREG; i++) begin
        cfg_q[i] <= dflt_q[i];                           // [R12]
      end
      changed <= '0;
    end else if (do_st_user) begin
      for (int i = 0; i < RVC_NREG; i++) begin
        if (changed[i]) begin
          user_q[i]     <= cfg_q[i];                     // [R13]
          user_valid[i] <= 1'b1;
        end
      end
    end else if (do_st_dflt) begin
      for (int i = 0; i < RVC_NREG; i++) begin
        dflt_q[i] <= cfg_q[i];                           // [R11]
      end
    end else if (do_wr) begin
      cfg_q[idx]   <= fit(idx, cmd_wdata);
      changed[idx] <= 1'b1;                              // [R13]
    end
  end

  // security level rises to one after any user restore
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      security_level <= `RVC_SEC_LEVEL_RST;
    end else if (do_rst_user) begin
      security_level <= `RVC_SEC_LEVEL_ONE;              // [R17]
    end
  end

  // fault clear pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_clear <= 1'b0;
    end else begin
      fault_clear <= is_send & (cmd_code == `RVC_CODE_CLEAR_FAULTS); // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to the host

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= take;
      rsp_err   <= take & ~ok;
      if (take && cmd_kind == RVC_READ) begin
        if (cmd_code == `RVC_CODE_VFMT) begin
          rsp_rdata <= {8'h00, VFMT};                    // [R18] [R19]
        end else if (hit) begin
          rsp_rdata <= cfg_q[idx];
        end else begin
          rsp_rdata <= 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable, turn-off style and target selection

  assign op  = cfg_q[RVC_I_OP][7:0];
  assign cfg = cfg_q[RVC_I_CFG][7:0];

  always_comb begin
    pin_ok = ~cfg[`RVC_CFG_PIN_EN] |
             (ctrl_pin == cfg[`RVC_CFG_PIN_POL]);        // [R7] [R8]
    bus_ok = ~cfg[`RVC_CFG_BUS_EN] |
             (op[`RVC_ONOFF_MSB:`RVC_ONOFF_LSB] == `RVC_ONOFF_ON); // [R1] [R2] [R6]
    if (cfg[`RVC_CFG_PWRUP]) begin
      next_enable = (cfg[`RVC_CFG_BUS_EN] | cfg[`RVC_CFG_PIN_EN]) & pin_ok & bus_ok; // [R5]
    end else begin
      next_enable = pin_ok & bus_ok;                     // [R6] [R7]
    end
    next_enable = next_enable & (state == RVC_READY);
    next_fast_off = ~next_enable &
      ((cfg[`RVC_CFG_BUS_EN] &
        (op[`RVC_ONOFF_MSB:`RVC_ONOFF_LSB] == `RVC_ONOFF_IMMED)) |     // [R1]
       (~pin_ok & cfg[`RVC_CFG_FAST_OFF]));                            // [R9]
    next_margin = op[`RVC_MARGIN_MSB:`RVC_MARGIN_LSB];
    if (next_margin != `RVC_MARGIN_LOW && next_margin != `RVC_MARGIN_HIGH) begin
      next_margin = `RVC_MARGIN_NOM;
    end
  end

  // registered output controls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_enable       <= 1'b0;
      out_fast_off     <= 1'b0;
      out_margin       <= `RVC_MARGIN_NOM;
      out_target       <= 16'h0000;
      out_trim         <= 16'h0000;
      out_cal          <= 16'h0000;
      out_fault_ignore <= 1'b0;
    end else begin
      out_enable   <= next_enable;
      out_fast_off <= next_fast_off;
      out_margin   <= next_margin;
      unique case (next_margin)
        `RVC_MARGIN_LOW:  out_target <= cfg_q[RVC_I_MLO]; // [R3] [R23]
        `RVC_MARGIN_HIGH: out_target <= cfg_q[RVC_I_MHI]; // [R3] [R23]
        default:          out_target <= cfg_q[RVC_I_NOM]; // [R3]
      endcase
      out_trim <= cfg_q[RVC_I_TRIM];
      out_cal  <= cfg_q[RVC_I_CAL];
      out_fault_ignore <= (next_margin != `RVC_MARGIN_NOM) &
        (op[`RVC_FAULT_MSB:`RVC_FAULT_LSB] == `RVC_FAULT_IGNORE); // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_bus_immed_off: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    cmd_ready && cfg[`RVC_CFG_BUS_EN] && op[7:6] == `RVC_ONOFF_IMMED
      |=> !out_enable && out_fast_off)
    else $error("immediate bus off not applied");

  a_bus_ignored: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    cmd_ready && !cfg[`RVC_CFG_BUS_EN] && cfg[`RVC_CFG_PIN_EN] && pin_ok
      |=> out_enable)
    else $error("on/off field acted without bus enable mode");

  a_margin_high: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    op[5:4] == `RVC_MARGIN_HIGH |=> out_target == $past(cfg_q[RVC_I_MHI]))
    else $error("margin high target not selected");

  a_fault_ignore: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    op[5:4] == `RVC_MARGIN_LOW && op[3:2] == `RVC_FAULT_ACT |=> !out_fault_ignore)
    else $error("faults ignored while act selected");

  a_pwrup_off: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    cfg[`RVC_CFG_PWRUP] && !cfg[`RVC_CFG_BUS_EN] && !cfg[`RVC_CFG_PIN_EN]
      |=> !out_enable)
    else $error("output on with no on source");

  a_pin_gate: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    cfg[`RVC_CFG_PIN_EN] && ctrl_pin != cfg[`RVC_CFG_PIN_POL] |=> !out_enable)
    else $error("output on while pin deasserted");

  a_clear_pulse: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    is_send && cmd_code == `RVC_CODE_CLEAR_FAULTS
      |=> (fault_clear && rsp_valid && !rsp_err) ##1 (!fault_clear || $past(is_send)))
    else $error("fault clear pulse wrong");

  a_dflt_locked: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    is_send && cmd_code == `RVC_CODE_STORE_DFLT && !dflt_unlock
      |=> rsp_valid && rsp_err && $stable(dflt_q[RVC_I_NOM]))
    else $error("locked default store not refused");

  a_trim_limit: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
    $signed(cfg_q[RVC_I_TRIM]) <= TRIM_LIM && $signed(cfg_q[RVC_I_TRIM]) >= -TRIM_LIM)
    else $error("trim offset beyond limit");

  a_boot_level: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    state == RVC_BOOT |=> security_level == `RVC_SEC_LEVEL_ONE && cmd_ready)
    else $error("boot restore did not set level one");

endmodule

`default_nettype wire

// ===== design/rvc_defines.svh
// command codes, field positions, reset values and limits of the regulator command decoder
`ifndef RVC_DEFINES_SVH
`define RVC_DEFINES_SVH
`define RVC_CODE_ONOFF_CTRL    8'h01
`define RVC_CODE_SRC_CFG       8'h02
`define RVC_CODE_CLEAR_FAULTS  8'h03
`define RVC_CODE_STORE_DFLT    8'h11
`define RVC_CODE_RESTORE_DFLT  8'h12
`define RVC_CODE_STORE_USER    8'h15
`define RVC_CODE_RESTORE_USER  8'h16
`define RVC_CODE_VFMT          8'h20
`define RVC_CODE_NOMINAL       8'h21
`define RVC_CODE_TRIM          8'h22
`define RVC_CODE_CAL           8'h23
`define RVC_CODE_MARGIN_HI     8'h25
`define RVC_CODE_MARGIN_LO     8'h26
`define RVC_ONOFF_MSB          7
`define RVC_ONOFF_LSB          6
`define RVC_MARGIN_MSB         5
`define RVC_MARGIN_LSB         4
`define RVC_FAULT_MSB          3
`define RVC_FAULT_LSB          2
`define RVC_CFG_PWRUP          4
`define RVC_CFG_BUS_EN         3
`define RVC_CFG_PIN_EN         2
`define RVC_CFG_PIN_POL        1
`define RVC_CFG_FAST_OFF       0
`define RVC_ONOFF_IMMED        2'h0
`define RVC_ONOFF_SOFT         2'h1
`define RVC_ONOFF_ON           2'h2
`define RVC_MARGIN_NOM         2'h0
`define RVC_MARGIN_LOW         2'h1
`define RVC_MARGIN_HIGH        2'h2
`define RVC_FAULT_IGNORE       2'h1
`define RVC_FAULT_ACT          2'h2
`define RVC_FMT_LINEAR         3'h0
`define RVC_FMT_EXP            5'h14
`define RVC_RST_ONOFF_CTRL     16'h0080
`define RVC_RST_SRC_CFG        16'h0016
`define RVC_RST_NOMINAL        16'h0ccd
`define RVC_RST_TRIM           16'h0000
`define RVC_RST_CAL            16'h0000
`define RVC_RST_MARGIN_HI      16'h0d70
`define RVC_RST_MARGIN_LO      16'h0c29
`define RVC_TRIM_LIMIT_MV      150
`define RVC_VOLT_SCALE         4096
`define RVC_MV_PER_V           1000
`define RVC_SEC_LEVEL_ONE      2'h1
`define RVC_SEC_LEVEL_RST      2'h0
`endif

// ===== design/rvc_pkg.sv
// types shared by the regulator command decoder
package rvc_pkg;
  localparam int RVC_NREG = 7;
  typedef enum logic [1:0] {RVC_SEND, RVC_WRITE, RVC_READ} rvc_kind_t;
  typedef enum logic [2:0] {RVC_I_OP, RVC_I_CFG, RVC_I_NOM, RVC_I_TRIM, RVC_I_CAL,
                            RVC_I_MHI, RVC_I_MLO} rvc_idx_t;
  typedef enum logic {RVC_BOOT, RVC_READY} rvc_state_t;
  typedef logic [15:0] rvc_word_t;
endpackage

// ===== verification/rvc_host.sv
// host-side model that issues commands on the decoder's command port
`include "rvc_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module rvc_host
  import rvc_pkg::*;
#(
  parameter int USER_WAIT_CYC = 200  // quiet time after user store/restore, shortened
)(
  input  wire logic      sys_clk,     // clock
  output logic           cmd_valid,   // command offered
  input  wire logic      cmd_ready,   // command can be taken
  output rvc_kind_t      cmd_kind,    // transfer kind
  output logic [7:0]     cmd_code,    // command code
  output logic [15:0]    cmd_wdata,   // write data
  input  wire logic      rsp_valid,   // answer pulse
  input  wire logic      rsp_err,     // refused
  input  wire rvc_word_t rsp_rdata,   // read data
  input  wire logic      fault_clear  // fault clear pulse
);
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = RVC_READ;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one transfer: hold until taken, release, then sample the answer cycle
  task automatic xfer(input rvc_kind_t k, input logic [7:0] c, input logic [15:0] d,
                      output logic got, output logic err, output rvc_word_t rd,
                      output logic fc, output logic tmo);
    logic rdy;
    rdy = 1'b0;
    tmo = 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_code <= c;
    cmd_wdata <= d;
    for (int i = 0; i < 20 && tmo; i++) begin
      @(negedge sys_clk);
      rdy = cmd_ready;
      @(posedge sys_clk);
      if (rdy) tmo = 1'b0;
    end
    // released code and data lines carry no stale copy of the request
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    @(negedge sys_clk);
    got = rsp_valid;
    err = rsp_err;
    rd = rsp_rdata;
    fc = fault_clear;
    if (k == RVC_SEND && (c == `RVC_CODE_STORE_USER || c == `RVC_CODE_RESTORE_USER))
      repeat (USER_WAIT_CYC) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// self-checking testbench of the regulator command decoder
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import rvc_pkg::*;
;
  typedef struct {logic [7:0] cfg; logic [7:0] op; logic pin; logic en; logic fast;} rvc_tb_ctl_t;
  typedef struct {logic [7:0] op; logic [1:0] mg; rvc_word_t tgt; logic ign;} rvc_tb_mg_t;

  logic       sys_clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_err, ctrl_pin, dflt_unlock;
  logic       out_enable, out_fast_off, out_fault_ignore, fault_clear;
  rvc_kind_t  cmd_kind;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  rvc_word_t  rsp_rdata, out_target, out_trim, out_cal, rdv;
  logic [1:0] out_margin, security_level;
  logic       last_fc;
  int         err_total, cmp_count;

  rvc_tb_ctl_t ctl [12] = '{'{8'h1e, 8'h80, 1'b1, 1'b1, 1'b0}, '{8'h1e, 8'h80, 1'b0, 1'b0, 1'b0},
    '{8'h1f, 8'h80, 1'b0, 1'b0, 1'b1}, '{8'h1b, 8'h80, 1'b0, 1'b1, 1'b0},
    '{8'h1b, 8'h00, 1'b0, 1'b0, 1'b1}, '{8'h1b, 8'h40, 1'b0, 1'b0, 1'b0},
    '{8'h14, 8'h00, 1'b0, 1'b1, 1'b0}, '{8'h14, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'h10, 8'h80, 1'b1, 1'b0, 1'b0}, '{8'h04, 8'h00, 1'b0, 1'b1, 1'b0},
    '{8'h04, 8'h00, 1'b1, 1'b0, 1'b0}, '{8'h08, 8'h00, 1'b1, 1'b0, 1'b1}};
  rvc_tb_mg_t mgt [4] = '{'{8'h94, 2'h1, 16'h0c29, 1'b1}, '{8'ha8, 2'h2, 16'h0d70, 1'b0},
    '{8'h64, 2'h2, 16'h0d70, 1'b1}, '{8'h80, 2'h0, 16'h0ccd, 1'b0}};

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  rvc_cmd dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .ctrl_pin(ctrl_pin), .dflt_unlock(dflt_unlock),
    .out_enable(out_enable), .out_fast_off(out_fast_off), .out_margin(out_margin),
    .out_target(out_target), .out_trim(out_trim), .out_cal(out_cal),
    .out_fault_ignore(out_fault_ignore), .fault_clear(fault_clear),
    .security_level(security_level));

  rvc_host host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .fault_clear(fault_clear));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and checking helpers
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic cmd(input rvc_kind_t k, input logic [7:0] c, input logic [15:0] d,
                     input logic exp_err);
    logic got, err, tmo;
    host.xfer(k, c, d, got, err, rdv, last_fc, tmo);
    if (tmo) begin
      err_total++;
      end_of_test();
    end
    chk("rsp_valid", 16'h0001, {15'h0, got});
    chk("rsp_err", {15'h0, exp_err}, {15'h0, err});
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cmd(RVC_WRITE, c, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    cmd(RVC_READ, c, 16'h0000, 1'b0);
    chk("read data", exp, rdv);
  endtask

  task automatic snd(input logic [7:0] c, input logic exp_err);
    cmd(RVC_SEND, c, 16'h0000, exp_err);
  endtask

  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    ctrl_pin = 1'b0;
    dflt_unlock = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (5) @(posedge sys_clk);
    chk("security_level", 16'h0000, {14'h0, security_level});
    rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("security_level", 16'h0001, {14'h0, security_level});
    rd(8'h20, 16'h0014);
    rd(8'h01, 16'h0080);
    rd(8'h02, 16'h0016);
    rd(8'h21, 16'h0ccd);
    rd(8'h25, 16'h0d70);
    rd(8'h26, 16'h0c29);
    $display("test reset done");

    // on/off source table
    foreach (ctl[i]) begin
      wr(8'h02, {8'h00, ctl[i].cfg});
      wr(8'h01, {8'h00, ctl[i].op});
      @(posedge sys_clk);
      ctrl_pin <= ctl[i].pin;
      settle();
      chk("out_enable", {15'h0, ctl[i].en}, {15'h0, out_enable});
      chk("out_fast_off", {15'h0, ctl[i].fast}, {15'h0, out_fast_off});
    end
    $display("test onoff done");

    // margin table
    foreach (mgt[i]) begin
      wr(8'h01, {8'h00, mgt[i].op});
      settle();
      chk("out_margin", {14'h0, mgt[i].mg}, {14'h0, out_margin});
      chk("out_target", mgt[i].tgt, out_target);
      chk("out_fault_ignore", {15'h0, mgt[i].ign}, {15'h0, out_fault_ignore});
    end
    $display("test margin done");

    // trim and calibration clamp at both ends
    for (int c = 8'h22; c <= 8'h23; c++) begin
      wr(c[7:0], 16'h1000);
      rd(c[7:0], 16'h0266);
      wr(c[7:0], 16'hf000);
      rd(c[7:0], 16'hfd9a);
    end
    settle();
    chk("out_trim", 16'hfd9a, out_trim);
    chk("out_cal", 16'hfd9a, out_cal);
    $display("test trim done");

    // fault clear pulse and refused transfers
    snd(8'h03, 1'b0);
    chk("fault_clear", 16'h0001, {15'h0, last_fc});
    settle();
    chk("fault_clear", 16'h0000, {15'h0, fault_clear});
    cmd(RVC_WRITE, 8'h20, 16'h00ff, 1'b1);
    rd(8'h20, 16'h0014);
    snd(8'h21, 1'b1);
    cmd(RVC_READ, 8'h03, 16'h0000, 1'b1);
    $display("test fault done");

    // user store and restore, then extending the user store
    wr(8'h21, 16'h0d00);
    snd(8'h15, 1'b0);
    wr(8'h21, 16'h0c00);
    snd(8'h16, 1'b0);
    rd(8'h21, 16'h0d00);
    chk("security_level", 16'h0001, {14'h0, security_level});
    snd(8'h16, 1'b0);
    wr(8'h22, 16'h0010);
    snd(8'h15, 1'b0);
    wr(8'h22, 16'h0000);
    wr(8'h21, 16'h0c40);
    snd(8'h16, 1'b0);
    rd(8'h22, 16'h0010);
    rd(8'h21, 16'h0d00);
    $display("test user store done");

    // default store: locked, then unlocked
    snd(8'h11, 1'b1);
    snd(8'h12, 1'b0);
    rd(8'h21, 16'h0ccd);
    rd(8'h22, 16'h0000);
    @(posedge sys_clk);
    dflt_unlock <= 1'b1;
    wr(8'h21, 16'h0c80);
    snd(8'h11, 1'b0);
    wr(8'h21, 16'h0c00);
    snd(8'h12, 1'b0);
    rd(8'h21, 16'h0c80);
    $display("test default store done");
    end_of_test();
  end
endmodule

`default_nettype wire
